// ### design/display_rail_enable_sequencer.sv
// Enable sequencer for the boost, positive LDO and negative pump rails.
// Assumes enable pins, soft-start flags and UVLO already synchronous.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`default_nettype none
module display_rail_enable_sequencer
  import rail_seq_pkg::*;
#(
  parameter int DELAY_CYC = SEQ_DELAY_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pos_rail_en_pin,
  input wire logic neg_rail_en_pin,
  input wire analog_in_t analog_in,
  output rail_ctl_t rail_ctl
);

  // Whole module state in one record
  // The record holds three groups of state:
  //  - the two software registers, status and enable
  //  - the previous pin levels, used to find falling and rising edges
  //  - one flag per rail plus a waiting flag and counter per delay
  // The waiting flags say that a 2ms delay is running; the counters
  // only count while their flag is set, and restart from zero each
  // time the event that starts them happens again.
  // The APB answer (read data, ready, error) sits here as well, so
  // that every port comes straight from this one register.
  // Pin edges are taken from the registered copy of the pin level;
  // after reset both copies are low, the idle level of a pulled-down
  // pin, so no false edge follows reset.
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] enable;
    logic pos_pin;
    logic neg_pin;
    logic pos_on;
    logic neg_on;
    logic boost_on;
    logic neg_wait;
    logic [DLY_W-1:0] neg_cnt;
    logic pos_off_wait;
    logic [DLY_W-1:0] off_cnt;
    logic dis_on;
    logic dis_wait;
    logic [DLY_W-1:0] dis_cnt;
    logic [31:0] rdata;
    logic ready;
    logic err;
    rail_ctl_t ctl;
  } state_t;

  state_t s_q, s_d;

  // Delay terminal value, sized to the counters
  localparam logic [DLY_W-1:0] DLY_END = DLY_W'(DELAY_CYC - 1);

  // Counter step: true when a running delay has expired
  // A counter starts at zero in the cycle its delay begins and is
  // compared with DELAY_CYC - 1, so a delay lasts DELAY_CYC cycles
  // from the edge that saw the trigger to the edge that acts on it.
  // The counter width limits DELAY_CYC to two to the DLY_W cycles;
  // a faster clock needs a wider counter.
  function automatic logic expired(input logic [DLY_W-1:0] c);
    expired = (c == DLY_END);
  endfunction

  // Next-state logic
  always_comb begin
    logic acc, pos_fall, neg_fall, neg_rise;
    logic uv, pos_req, neg_req, boost_req, together;
    // Locals start from known values on every pass
    acc = 1'b0;
    pos_fall = 1'b0;
    neg_fall = 1'b0;
    neg_rise = 1'b0;
    uv = 1'b0;
    pos_req = 1'b0;
    neg_req = 1'b0;
    boost_req = 1'b0;
    together = 1'b0;
    s_d = s_q;
    acc = psel && penable && !s_q.ready;
    // Pins are pulled down off chip; X never arrives here
    s_d.pos_pin = pos_rail_en_pin;
    s_d.neg_pin = neg_rail_en_pin;
    pos_fall = s_q.pos_pin && !pos_rail_en_pin;
    neg_fall = s_q.neg_pin && !neg_rail_en_pin;
    neg_rise = !s_q.neg_pin && neg_rail_en_pin;
    uv = !analog_in.uvlo_ok;
    together = s_q.status[SEQ_TOGETHER_BIT];
    pos_req = pos_rail_en_pin && s_q.enable[POS_EN_BIT];
    neg_req = neg_rail_en_pin && s_q.enable[NEG_EN_BIT];
    boost_req = s_q.enable[BOOST_EN_BIT] &&
        (pos_rail_en_pin || neg_rail_en_pin);

    // Positive rail start after boost soft-start
    // The rail starts only once the boost is on and reports its
    // soft-start done. When the pin falls with the off delay chosen,
    // the rail stays up and a 2ms count begins; the pin rising again
    // during that count cancels it and keeps the rail on.
    // With the no-delay bit set the rail drops at the pin's fall.
    if (pos_req && analog_in.boost_ss_done && s_q.boost_on) begin
      s_d.pos_on = 1'b1;
      s_d.pos_off_wait = 1'b0;
    end else if (pos_fall && !s_q.enable[OFF_NODELAY_BIT] && s_q.pos_on) begin
      s_d.pos_off_wait = 1'b1;
      s_d.off_cnt = '0;
    end else if (!pos_req && !s_q.pos_off_wait) begin
      s_d.pos_on = 1'b0;
    end
    // Off delay count
    if (s_q.pos_off_wait) begin
      if (pos_req) begin
        s_d.pos_off_wait = 1'b0;
      end else if (expired(s_q.off_cnt)) begin
        s_d.pos_off_wait = 1'b0;
        s_d.pos_on = 1'b0;
      end else begin
        s_d.off_cnt = s_q.off_cnt + 1'b1;
      end
    end

    // Boost: held on while positive off-delay runs
    // Uses the next off-delay flag so the boost does not blink off
    // for one cycle while the positive delay is just starting, and so
    // boost and positive rail drop in the same cycle at its end.
    s_d.boost_on = (boost_req || s_d.pos_off_wait) && !uv;
    if (!pos_rail_en_pin && !neg_rail_en_pin &&
        !s_d.pos_off_wait) begin
      s_d.boost_on = 1'b0;
    end

    // Negative rail start
    // Sequenced mode: the 2ms count starts at the later of boost done
    // and the pin high, since losing either clears the wait flag and
    // the count restarts when both hold again.
    // Together mode: the rail starts with the positive rail, in the
    // first cycle after the boost has finished its soft-start.
    if (!neg_req || !analog_in.boost_ss_done || !s_q.boost_on) begin
      s_d.neg_on = 1'b0;
      s_d.neg_wait = 1'b0;
    end else if (!s_q.neg_on) begin
      if (together) begin
        s_d.neg_on = 1'b1;
      end else if (!s_q.neg_wait || neg_rise) begin
        s_d.neg_wait = 1'b1;
        s_d.neg_cnt = '0;
      end else if (expired(s_q.neg_cnt)) begin
        s_d.neg_on = 1'b1;
        s_d.neg_wait = 1'b0;
      end else begin
        s_d.neg_cnt = s_q.neg_cnt + 1'b1;
      end
    end

    // Discharge resistor on the positive rail
    // Engaged when the negative pin falls; released after 2ms only if
    // the positive pin is still high then. It is also engaged while
    // the positive pin is low, and dropped while the positive rail
    // runs with no pending release.
    // Hi-Z mode masks it at the output, not here, so the state is kept
    // and the resistor returns as soon as Hi-Z is cleared.
    if (neg_fall) begin
      s_d.dis_on = 1'b1;
      s_d.dis_wait = pos_rail_en_pin;
      s_d.dis_cnt = '0;
    end else if (pos_fall || !pos_rail_en_pin) begin
      s_d.dis_on = !s_q.pos_on || pos_fall || s_q.dis_on;
      s_d.dis_wait = 1'b0;
    end else if (s_q.dis_wait) begin
      if (expired(s_q.dis_cnt)) begin
        s_d.dis_on = 1'b0;
        s_d.dis_wait = 1'b0;
      end else begin
        s_d.dis_cnt = s_q.dis_cnt + 1'b1;
      end
    end else if (s_q.pos_on) begin
      s_d.dis_on = 1'b0;
    end

    // Undervoltage drops every rail in one cycle
    // Placed last among the rail updates so it wins over every start,
    // and the positive off delay and negative start delay are dropped so no rail restarts by itself;
    // the registers keep their contents through undervoltage.
    if (uv) begin
      s_d.boost_on = 1'b0;
      s_d.pos_on = 1'b0;
      s_d.neg_on = 1'b0;
      s_d.pos_off_wait = 1'b0;
      s_d.neg_wait = 1'b0;
    end

    // Outputs registered from next state
    // Taking the outputs from the next state keeps every port on a
    // flip-flop without adding a cycle of lag behind the rail flags.
    s_d.ctl.boost_rail_en = s_d.boost_on;
    s_d.ctl.pos_ldo_rail_en = s_d.pos_on;
    s_d.ctl.neg_pump_rail_en = s_d.neg_on;
    s_d.ctl.pos_discharge_en = s_d.dis_on && !s_q.enable[HIZ_BIT];
    s_d.ctl.pulldown_off = s_q.enable[HIZ_BIT];
    // Ramp rate is fixed in the regulator; only the time base is chosen
    s_d.ctl.fast_soft_start = s_q.enable[FAST_SS_BIT];

    // APB slave: one wait state, answer in second access cycle
    // The access is taken in the first access cycle; a write lands at
    // that edge and the answer shows one cycle later for one cycle.
    // Ready itself blocks a second take of the same access, since the
    // master still holds psel and penable in the answer cycle.
    // Unmapped addresses answer with an error and read as zero.
    // Only the low byte of each register is kept; upper bits read 0.
    s_d.ready = acc;
    s_d.err = 1'b0;
    s_d.rdata = '0;
    if (acc) begin
      unique case (paddr)
        STATUS_OFFSET: begin
          if (pwrite) begin
            s_d.status = pwdata[7:0];
          end
          s_d.rdata = {24'h00_0000, s_q.status};
        end
        ENABLE_OFFSET: begin
          if (pwrite) begin
            s_d.enable = pwdata[7:0];
          end
          s_d.rdata = {24'h00_0000, s_q.enable};
        end
        RAIL_STATE_OFFSET: begin
          // Read-only live view of the sequencer
          s_d.rdata = {26'h000_0000, s_q.ctl};
        end
        default: begin
          s_d.err = 1'b1;
        end
      endcase
    end
  end

  // State register
  // Reset loads only constants: registers to their reset values, the
  // discharge resistor engaged and every rail off. The pin copies
  // reset low to match the pulled-down idle level of the pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.status <= STATUS_RESET;
      s_q.enable <= ENABLE_RESET;
      s_q.dis_on <= 1'b1;
      s_q.ctl.pos_discharge_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Ports are plain wires from the state register
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign rail_ctl = s_q.ctl;

endmodule
`default_nettype wire

// ### design/rail_seq_pkg.sv
// Package for the display rail enable sequencer.
// Assumes a 50 MHz pclk and a 32-bit APB register bus.
`default_nettype none
package rail_seq_pkg;
  // Register indices; each register is one aligned word at four times it
  localparam int STATUS_IDX = 4;
  localparam int ENABLE_IDX = 5;
  localparam int RAIL_STATE_IDX = 6;
  // Register byte offsets
  localparam logic [11:0] STATUS_OFFSET = 12'(STATUS_IDX * 4);
  localparam logic [11:0] ENABLE_OFFSET = 12'(ENABLE_IDX * 4);
  localparam logic [11:0] RAIL_STATE_OFFSET = 12'(RAIL_STATE_IDX * 4);
  // Status register field: start both rails together
  localparam int SEQ_TOGETHER_BIT = 4;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Enable register fields
  localparam int BOOST_EN_BIT = 0;
  localparam int NEG_EN_BIT = 1;
  localparam int POS_EN_BIT = 2;
  localparam int OFF_NODELAY_BIT = 4;
  localparam int UV_SHUTDOWN_BIT = 5;
  localparam int HIZ_BIT = 6;
  localparam int FAST_SS_BIT = 7;
  localparam logic [7:0] ENABLE_RESET = 8'h27;
  // Times in microseconds and clock rate
  localparam int CLK_HZ = 50_000_000;
  localparam int SEQ_DELAY_US = 2000;
  localparam int SEQ_DELAY_CYC = SEQ_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int DLY_W = 17;

  // Inputs that arrive from the analog side
  typedef struct packed {
    logic uvlo_ok;
    logic boost_ss_done;
    logic pos_ss_done;
    logic neg_ss_done;
  } analog_in_t;

  // Rail control outputs
  typedef struct packed {
    logic boost_rail_en;
    logic pos_ldo_rail_en;
    logic neg_pump_rail_en;
    logic pos_discharge_en;
    logic pulldown_off;
    logic fast_soft_start;
  } rail_ctl_t;
endpackage
`default_nettype wire

// ### testbench/rail_checker.sv
// Checker for rail outputs and APB answer timing.
// Assumes it is bound onto the sequencer top module.
`default_nettype none
module rail_checker
  import rail_seq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pos_rail_en_pin,
  input wire logic neg_rail_en_pin,
  input wire analog_in_t analog_in,
  input wire rail_ctl_t rail_ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // First access cycle, answer not yet given
  sequence s_access;
    psel && penable && !pready;
  endsequence
  property p_ready_lat;
    s_access |=> pready;
  endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("pready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_boost_start;
    $rose(rail_ctl.boost_rail_en) |-> $past(analog_in.uvlo_ok) &&
      ($past(pos_rail_en_pin) || $past(neg_rail_en_pin));
  endproperty
  a_boost_start: assert property (p_boost_start) else $error("boost");
  property p_pos_start;
    $rose(rail_ctl.pos_ldo_rail_en) |->
      $past(pos_rail_en_pin) && $past(analog_in.boost_ss_done);
  endproperty
  a_pos_start: assert property (p_pos_start) else $error("pos start");
  property p_neg_pin;
    rail_ctl.neg_pump_rail_en |-> $past(neg_rail_en_pin);
  endproperty
  a_neg_pin: assert property (p_neg_pin) else $error("neg pin");
  property p_neg_start;
    $rose(rail_ctl.neg_pump_rail_en) |-> $past(analog_in.boost_ss_done);
  endproperty
  a_neg_start: assert property (p_neg_start) else $error("neg start");
  property p_uvlo_off;
    !analog_in.uvlo_ok |=> rail_ctl[5:3] == 3'b000;
  endproperty
  a_uvlo_off: assert property (p_uvlo_off) else $error("uvlo");
  property p_hiz;
    rail_ctl.pulldown_off |-> !rail_ctl.pos_discharge_en;
  endproperty
  a_hiz: assert property (p_hiz) else $error("hi-z discharge");
endmodule
bind display_rail_enable_sequencer rail_checker rail_checker_i (.pclk,
  .presetn, .psel, .penable, .pready, .pos_rail_en_pin, .neg_rail_en_pin,
  .analog_in, .rail_ctl);
`default_nettype wire

// ### testbench/host_pin_model.sv
// Host side of the two enable pins.
// Assumes the bench sets levels and releases pins by the drive flags.
`default_nettype none
module host_pin_model (
  input wire logic pos_want,
  input wire logic neg_want,
  input wire logic pos_drv,
  input wire logic neg_drv,
  output logic pos_pin,
  output logic neg_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pin falls to its pull-down level
  assign pos_pin = pos_drv ? pos_want : 1'b0;
  assign neg_pin = neg_drv ? neg_want : 1'b0;
endmodule
`default_nettype wire

// ### testbench/display_rail_enable_sequencer_tb.sv
// Self-checking bench for the rail enable sequencer.
// Assumes the pin model and the bound checker are compiled with it.
`default_nettype none
module display_rail_enable_sequencer_tb
  import rail_seq_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, pos_pin, neg_pin;
  logic pos_want = 1, neg_want = 1, pos_drv = 0, neg_drv = 0;
  analog_in_t analog_in = '0;
  rail_ctl_t rail_ctl;
  int failures = 0, checks = 0;
  // Short delay count keeps the run brief
  display_rail_enable_sequencer #(.DELAY_CYC(20))
    display_rail_enable_sequencer_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pos_rail_en_pin(pos_pin), .neg_rail_en_pin(neg_pin), .analog_in,
    .rail_ctl);
  host_pin_model host_pin_model_i (.pos_want, .neg_want, .pos_drv,
    .neg_drv, .pos_pin, .neg_pin);
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    chk("rails", 8'h04, 8'(rail_ctl));
    apb(1'b0, ENABLE_OFFSET, 32'h0000_0000);
    chk("enable", 8'h27, rd[7:0]);
    apb(1'b0, 12'h0ff, 32'h0000_0000);
    chk("slverr", 8'h01, 8'(err));
    $display("test reset done");
  endtask
  task automatic t_on();
    analog_in.uvlo_ok <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("float", 8'h00, 8'(rail_ctl[5]));
    analog_in.uvlo_ok <= 1'b0;
    pos_drv <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("uvlo", 8'h00, 8'(rail_ctl[5]));
    analog_in.uvlo_ok <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("boost", 8'h01, 8'(rail_ctl[5]));
    chk("pos wait", 8'h00, 8'(rail_ctl[4]));
    analog_in.boost_ss_done <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("pos", 8'h01, 8'(rail_ctl[4]));
    neg_drv <= 1'b1;
    repeat (12) @(posedge pclk);
    chk("neg early", 8'h00, 8'(rail_ctl[3]));
    repeat (12) @(posedge pclk);
    chk("neg", 8'h01, 8'(rail_ctl[3]));
    $display("test on done");
  endtask
  task automatic t_off();
    neg_want <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("neg off", 8'h00, 8'(rail_ctl[3]));
    chk("dis on", 8'h01, 8'(rail_ctl[2]));
    repeat (25) @(posedge pclk);
    chk("dis off", 8'h00, 8'(rail_ctl[2]));
    pos_want <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("pos hold", 8'h01, 8'(rail_ctl[4]));
    chk("boost hold", 8'h01, 8'(rail_ctl[5]));
    repeat (25) @(posedge pclk);
    chk("all off", 8'h00, 8'(rail_ctl[5:3]));
    $display("test off done");
  endtask
  task automatic t_uv();
    apb(1'b1, ENABLE_OFFSET, 32'h0000_00f7);
    chk("hiz", 8'h01, 8'(rail_ctl[2:1]));
    chk("fast", 8'h01, 8'(rail_ctl[0]));
    pos_want <= 1'b1;
    neg_want <= 1'b1;
    repeat (30) @(posedge pclk);
    chk("up", 8'h07, 8'(rail_ctl[5:3]));
    pos_want <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pos now", 8'h00, 8'(rail_ctl[4]));
    pos_want <= 1'b1;
    repeat (3) @(posedge pclk);
    analog_in.uvlo_ok <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("uv off", 8'h00, 8'(rail_ctl[5:3]));
    $display("test uvlo done");
  endtask
  // Together mode, then a reset in mid-run
  task automatic t_together();
    apb(1'b1, STATUS_OFFSET, 32'h0000_0010);
    apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
    chk("status", 8'h10, rd[7:0]);
    analog_in.uvlo_ok <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("boost first", 8'h04, 8'(rail_ctl[5:3]));
    @(posedge pclk);
    chk("together", 8'h07, 8'(rail_ctl[5:3]));
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset rails", 8'h04, 8'(rail_ctl));
    apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
    chk("status reset", 8'h00, rd[7:0]);
    apb(1'b0, ENABLE_OFFSET, 32'h0000_0000);
    chk("enable reset", 8'h27, rd[7:0]);
    $display("test together done");
  endtask
  // Cuts a hang short after several times the expected run
  initial begin
    repeat (1000) @(posedge pclk);
    failures++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_on();
    t_off();
    t_uv();
    t_together();
    summarize();
  end
endmodule
`default_nettype wire
